// file: sdd_params.svh
/*
  register offsets, field positions, reset values and timing counts
  of the sinc3 decimation datapath. assumes a 125 MHz aclk.
*/
`ifndef SDD_PARAMS_SVH
`define SDD_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SDD_OFF_CFG1 8'h00
`define SDD_OFF_CFG3 8'h04
`define SDD_OFF_CTRL 8'h08
`define SDD_OFF_IRQ_STAT 8'h0C
`define SDD_OFF_IRQ_CLR 8'h10
`define SDD_OFF_IRQ_EN 8'h14
`define SDD_OFF_CLK_STAT 8'h18
`define SDD_OFF_RESULT 8'h20
`define SDD_OFF_RESULT_END 8'h3C

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SDD_CFG1_RATE_LSB 0
`define SDD_CFG1_CLK_OUT_EN_BIT 5
`define SDD_CFG1_RESET 8'h06
`define SDD_CFG3_REFBUF_PWR_BIT 7
`define SDD_CFG3_RESET 8'h00
`define SDD_CTRL_START_BIT 0
`define SDD_IRQ_RESULT_BIT 0
`define SDD_IRQ_CLIP_BIT 1

// ----------------------------------------
// datapath figures
// ----------------------------------------
`define SDD_MOD_DIV 2
`define SDD_LOG2_N_MAX 12
`define SDD_RATE_MAX 3'h6
`define SDD_SETTLE_OUTPUTS 3
`define SDD_RDY_LOW_CYCLES 8
`define SDD_CODE_BITS 24
`define SDD_CODE_POS_FS 24'h7FFFFF
`define SDD_CODE_NEG_FS 24'h800000
`define SDD_RESP_OKAY 2'h0
`define SDD_RESP_SLVERR 2'h2

`endif

// file: sdd_pkg.sv
/*
  types shared by the sinc3 decimation datapath.
  writes its widths as literals, not from sdd_params.svh.
*/
package sdd_pkg;
  typedef logic signed [37:0] sdd_acc_t;
  typedef logic [23:0] sdd_code_t;
  typedef enum logic [1:0] {
    SDD_HALTED,
    SDD_SETTLING,
    SDD_RUNNING
  } sdd_state_t;
endpackage

// file: sdd_datapath.sv
/*
  eight-channel sinc3 decimation datapath with axi4-lite register slave,
  clock source selection, clip flags and a level interrupt.
  assumes modulator bitstreams, start and clock select arrive as pins
  asynchronous to aclk; the clock pin is split into in, out and enable.
*/
`include "sdd_params.svh"

// Functional notes
// [R1] modulator takes one sample every two master clock periods
// [R2] each channel runs its own third-order sinc filter of length N
// [R3] one rate field in first config register sets N for all channels
// [R4] filter emits one result word per decimation period
// [R5] moving-sum structure places nulls at the output rate and multiples
// [R6] results settle within three output periods after a step
// [R7] after start, first result only after the settling interval
// [R8] select pin low uses clock pin input, high uses internal oscillator
// [R9] with oscillator selected, output enable bit drives or floats clock pin
// [R10] results are 24-bit two's complement words, msb first
// [R11] results saturate at 7FFFFF and 800000, never wrap
// [R12] one code step is reference over two to 23 minus one
// [R13] full 24-bit mapping holds only at 24-bit resolution rates
// [R14] reference buffer powers up down, enabled only by its control bit
// [R15] active-low data-ready falls on each new result set
// [R16] writing the first config register resets all filter state
// [R17] without start pin or start command, datapath halts, no data-ready
// [R18] three integrators at modulator rate, three differentiators decimated
// [R19] output scaled and rounded to 24 bits, all channels one tick
module sdd_datapath import sdd_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] mod_bit,
  input wire logic start_pin,
  input wire logic clock_source_select_pin,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_n,
  output logic internal_clk_sel,
  output logic reference_buffer_power,
  output logic result_ready_n,
  output logic irq
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [3:0] rate_log2(input logic [2:0] rate);
    logic [2:0] r;
    r = (rate > `SDD_RATE_MAX) ? `SDD_RATE_MAX : rate;
    return 4'(`SDD_LOG2_N_MAX) - {1'b0, r};
  endfunction

  function automatic logic [24:0] scale_sat(input sdd_acc_t v, input logic [3:0] lg);
    logic signed [63:0] w;
    logic [5:0] sh;
    w = 64'(v) <<< (`SDD_CODE_BITS - 1);
    sh = 6'(lg) * 6'h3;
    w = w + (64'sh1 <<< (sh - 6'h1));
    w = w >>> sh;
    if (w > 64'sh7FFFFF) begin
      return {1'b1, `SDD_CODE_POS_FS};
    end else if (w < -64'sh800000) begin
      return {1'b1, `SDD_CODE_NEG_FS};
    end
    return {1'b0, w[23:0]};
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] mod_meta_q, mod_sync_q;
  logic start_meta_q, start_sync_q, sel_meta_q, sel_sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_meta_q <= 8'h00;
      mod_sync_q <= 8'h00;
      start_meta_q <= 1'b0;
      start_sync_q <= 1'b0;
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end else begin
      mod_meta_q <= mod_bit;
      mod_sync_q <= mod_meta_q;
      start_meta_q <= start_pin;
      start_sync_q <= start_meta_q;
      sel_meta_q <= clock_source_select_pin;
      sel_sync_q <= sel_meta_q;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] cfg1_q, cfg3_q, irq_stat_q, irq_en_q;
  logic start_cmd_q, cfg1_wr;
  logic [1:0] irq_set;
  logic aw_got_q, w_got_q, wr_fire;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  sdd_code_t res_q [8];

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign cfg1_wr = wr_fire && aw_addr_q == `SDD_OFF_CFG1 && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg1_q <= `SDD_CFG1_RESET;
      cfg3_q <= `SDD_CFG3_RESET; // R14
      start_cmd_q <= 1'b0;
      irq_en_q <= 8'h00;
    end else if (wr_fire && w_strb_q[0]) begin
      unique case (aw_addr_q)
        `SDD_OFF_CFG1: cfg1_q <= w_data_q[7:0];
        `SDD_OFF_CFG3: cfg3_q <= w_data_q[7:0]; // R14
        `SDD_OFF_CTRL: start_cmd_q <= w_data_q[`SDD_CTRL_START_BIT];
        `SDD_OFF_IRQ_EN: irq_en_q <= w_data_q[7:0];
        default: ;
      endcase
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 8'h00;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (b < 2 && irq_set[b]) begin
          irq_stat_q[b] <= 1'b1;
        end else if (wr_fire && w_strb_q[0] && aw_addr_q == `SDD_OFF_IRQ_CLR && w_data_q[b]) begin
          irq_stat_q[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // ----------------------------------------
  // clock source and reference buffer
  // ----------------------------------------
  logic osc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q <= 1'b0;
      clk_pin_o <= 1'b0;
      clk_pin_oe_n <= 1'b1;
      internal_clk_sel <= 1'b0;
      reference_buffer_power <= 1'b0;
    end else begin
      osc_q <= ~osc_q;
      internal_clk_sel <= sel_sync_q; // R8
      clk_pin_o <= osc_q;
      clk_pin_oe_n <= !(sel_sync_q && cfg1_q[`SDD_CFG1_CLK_OUT_EN_BIT]); // R9
      reference_buffer_power <= cfg3_q[`SDD_CFG3_REFBUF_PWR_BIT]; // R14
    end
  end

  // ----------------------------------------
  // sinc3 filter
  // ----------------------------------------
  logic run, mod_tick, dec_tick;
  logic mod_phase_q;
  logic [11:0] dec_cnt_q;
  logic [3:0] lg;
  logic [1:0] settle_q;
  sdd_state_t state_q;
  sdd_acc_t i1_q [8], i2_q [8], i3_q [8];
  sdd_acc_t d1_q [8], d2_q [8], d3_q [8];
  sdd_acc_t c1 [8], c2 [8], c3 [8];
  logic [24:0] sc [8];
  logic any_clip;

  assign run = start_sync_q || start_cmd_q; // R17
  assign lg = rate_log2(cfg1_q[`SDD_CFG1_RATE_LSB +: 3]); // R3
  assign mod_tick = mod_phase_q; // R1
  assign dec_tick = mod_tick && dec_cnt_q == 12'((13'h1 << lg) - 13'h1); // R4

  always_comb begin
    any_clip = 1'b0;
    for (int c = 0; c < 8; c++) begin
      c1[c] = i3_q[c] - d1_q[c]; // R18
      c2[c] = c1[c] - d2_q[c];
      c3[c] = c2[c] - d3_q[c]; // R2 R5
      sc[c] = scale_sat(c3[c], lg); // R11 R12 R19
      any_clip = any_clip | sc[c][24];
    end
  end

  // modulator phase and decimation counter
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || cfg1_wr) begin
      mod_phase_q <= 1'b0;
      dec_cnt_q <= 12'h000;
    end else begin
      mod_phase_q <= ~mod_phase_q; // R1
      if (dec_tick) begin
        dec_cnt_q <= 12'h000;
      end else if (mod_tick) begin
        dec_cnt_q <= dec_cnt_q + 12'h001;
      end
    end
  end

  // integrators at modulator rate, differentiators at decimated rate
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || cfg1_wr) begin // R16 R17
      for (int c = 0; c < 8; c++) begin
        i1_q[c] <= '0;
        i2_q[c] <= '0;
        i3_q[c] <= '0;
        d1_q[c] <= '0;
        d2_q[c] <= '0;
        d3_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 8; c++) begin
        if (mod_tick) begin
          i1_q[c] <= i1_q[c] + (mod_sync_q[c] ? 38'sh1 : -38'sh1); // R18
          i2_q[c] <= i2_q[c] + i1_q[c];
          i3_q[c] <= i3_q[c] + i2_q[c];
        end
        if (dec_tick) begin
          d1_q[c] <= i3_q[c]; // R18
          d2_q[c] <= c1[c];
          d3_q[c] <= c2[c];
        end
      end
    end
  end

  // settling: the comb memory needs three outputs before results are valid
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || cfg1_wr) begin
      state_q <= SDD_HALTED;
      settle_q <= 2'h0;
    end else begin
      unique case (state_q)
        SDD_HALTED: state_q <= SDD_SETTLING;
        SDD_SETTLING: begin
          if (dec_tick) begin
            settle_q <= settle_q + 2'h1;
            if (settle_q == 2'(`SDD_SETTLE_OUTPUTS - 1)) begin
              state_q <= SDD_RUNNING; // R6 R7
            end
          end
        end
        SDD_RUNNING: ;
      endcase
    end
  end

  logic new_result;
  logic [3:0] rdy_cnt_q;

  assign new_result = dec_tick && (state_q == SDD_RUNNING ||
    (state_q == SDD_SETTLING && settle_q == 2'(`SDD_SETTLE_OUTPUTS - 1))); // R7
  assign irq_set = {new_result && any_clip, new_result};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < 8; c++) begin
        res_q[c] <= 24'h000000;
      end
    end else if (new_result) begin
      for (int c = 0; c < 8; c++) begin
        res_q[c] <= sc[c][23:0]; // R10 R13 R19
      end
    end
  end

  // data-ready: low pulse per result set, no chip select involved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ready_n <= 1'b1;
      rdy_cnt_q <= 4'h0;
    end else if (new_result) begin
      result_ready_n <= 1'b0; // R15
      rdy_cnt_q <= 4'(`SDD_RDY_LOW_CYCLES - 1);
    end else if (rdy_cnt_q != 4'h0) begin
      rdy_cnt_q <= rdy_cnt_q - 4'h1;
    end else begin
      result_ready_n <= 1'b1;
    end
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  logic wr_mapped;

  assign wr_mapped = aw_addr_q <= `SDD_OFF_CLK_STAT && aw_addr_q[1:0] == 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDD_RESP_OKAY;
    end else begin
      if (!aw_got_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_got_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `SDD_RESP_OKAY : `SDD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  logic [31:0] rd_word;
  logic rd_ok;

  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr >= `SDD_OFF_RESULT && s_axi_araddr <= `SDD_OFF_RESULT_END &&
        s_axi_araddr[1:0] == 2'h0) begin
      rd_word = {8'h00, res_q[s_axi_araddr[4:2]]}; // R10
    end else begin
      unique case (s_axi_araddr)
        `SDD_OFF_CFG1: rd_word = {24'h000000, cfg1_q};
        `SDD_OFF_CFG3: rd_word = {24'h000000, cfg3_q};
        `SDD_OFF_CTRL: rd_word = {31'h00000000, start_cmd_q};
        `SDD_OFF_IRQ_STAT: rd_word = {24'h000000, irq_stat_q};
        `SDD_OFF_IRQ_CLR: rd_word = 32'h00000000;
        `SDD_OFF_IRQ_EN: rd_word = {24'h000000, irq_en_q};
        `SDD_OFF_CLK_STAT: rd_word = {28'h0000000, state_q == SDD_RUNNING, run, !clk_pin_oe_n,
          internal_clk_sel};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SDD_RESP_OKAY;
    end else begin
      if (!s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `SDD_RESP_OKAY : `SDD_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: sdd_checker_properties.sv
/*
  port assertions for the sinc3 decimation datapath.
  assumes one aclk domain with sync active-low aresetn.
*/
module sdd_checker (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic clock_source_select_pin,
  input logic clk_pin_o,
  input logic clk_pin_oe_n,
  input logic internal_clk_sel,
  input logic reference_buffer_power,
  input logic result_ready_n,
  input logic irq
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_rdy_len;
    $fell(result_ready_n) |-> (!result_ready_n) [*8] ##1 result_ready_n;
  endproperty
  a_rdy_len: assert property (p_rdy_len) else $error("ready pulse length wrong");

  property p_oe_sel;
    !clk_pin_oe_n |-> internal_clk_sel || $past(internal_clk_sel);
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("clock pin driven without oscillator");

  property p_osc_out;
    !clk_pin_oe_n && !$past(clk_pin_oe_n) |-> clk_pin_o != $past(clk_pin_o);
  endproperty
  a_osc_out: assert property (p_osc_out) else $error("driven clock pin not toggling");

  property p_sel;
    clock_source_select_pin [*6] |=> internal_clk_sel;
  endproperty
  a_sel: assert property (p_sel) else $error("oscillator not selected");

  property p_desel;
    (!clock_source_select_pin) [*6] |=> clk_pin_oe_n;
  endproperty
  a_desel: assert property (p_desel) else $error("clock pin not input");

  property p_ref;
    $rose(reference_buffer_power) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_ref: assert property (p_ref) else $error("buffer powered without write");

  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer wrong");

  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer wrong");

  c_rdy: cover property ($fell(result_ready_n));
  c_irq: cover property ($rose(irq));
  c_ref: cover property ($rose(reference_buffer_power));
endmodule

bind sdd_datapath sdd_checker u_chk (
  .aclk,
  .aresetn,
  .s_axi_awvalid,
  .s_axi_awready,
  .s_axi_wvalid,
  .s_axi_wready,
  .s_axi_bvalid,
  .s_axi_arvalid,
  .s_axi_arready,
  .s_axi_rvalid,
  .clock_source_select_pin,
  .clk_pin_o,
  .clk_pin_oe_n,
  .internal_clk_sel,
  .reference_buffer_power,
  .result_ready_n,
  .irq
);

// file: sdd_mod_src.sv
/*
  modulator bitstream source for all eight channels.
  assumes the bench changes mode only between runs.
*/
module sdd_mod_src (
  input logic aclk,
  input logic [1:0] mode,
  output logic [7:0] mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_q = 1'b0;
  logic alt_q = 1'b0;

  // alternate value once per modulator sample
  always_ff @(posedge aclk) begin
    ph_q <= ~ph_q;
    if (ph_q) begin
      alt_q <= ~alt_q;
    end
  end

  assign mod_bit = (mode == 2'h2) ? {8{alt_q}} : {8{mode[0]}};
endmodule

// file: tb_top.sv
/*
  self-checking bench for the sinc3 decimation datapath.
  assumes rate field 6, so N is 64 and 128 aclk per result.
*/
`include "sdd_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, start_pin, clock_source_select_pin, clk_pin_i;
  logic clk_pin_o, clk_pin_oe_n, internal_clk_sel, reference_buffer_power, result_ready_n, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mod_bit;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode, r;
  int n_fail, checked, n;
  localparam int PER = `SDD_MOD_DIV * (1 << (`SDD_LOG2_N_MAX - 6));

  sdd_datapath dut (.*);
  sdd_mod_src src (.aclk, .mode, .mod_bit);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ----
  // tasks
  // ----
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, d);
    chk(nm, `SDD_RESP_OKAY, 32'(r));
  endtask

  task automatic wait_rdy(input int lim);
    bit hi;
    hi = 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (result_ready_n) hi = 1'b1;
    end while (!(hi && !result_ready_n) && n < lim);
    if (result_ready_n) n = -1;
  endtask

  task automatic res(input logic [31:0] e);
    for (int c = 0; c < 8; c++) begin
      rchk("result", `SDD_OFF_RESULT + 8'(4 * c), e);
    end
  endtask

  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end

  // ----
  // tests
  // ----
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {start_pin, clock_source_select_pin, clk_pin_i, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    mode = 2'h0;
    n_fail = 0;
    checked = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("cfg1", `SDD_OFF_CFG1, 32'h6);
    rchk("cfg3", `SDD_OFF_CFG3, 32'h0);
    chk("refbuf", 32'h0, 32'(reference_buffer_power));
    rd(8'h40);
    chk("unmapped resp", 32'(`SDD_RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    wait_rdy(3 * PER);
    chk("halted", 32'hFFFFFFFF, 32'(n));
    wr(`SDD_OFF_IRQ_EN, 32'h3);
    mode <= 2'h1;
    start_pin <= 1'b1;
    wait_rdy(5 * PER);
    chk("settle", 32'h1, 32'(n >= 3 * PER && n < 4 * PER));
    wait_rdy(2 * PER);
    chk("period", 32'(PER), 32'(n));
    res(32'h7FFFFF);
    chk("irq", 32'h1, 32'(irq));
    rchk("status", `SDD_OFF_IRQ_STAT, 32'h3);
    start_pin <= 1'b0;
    wr(`SDD_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge aclk);
    chk("masked", 32'h0, 32'(irq));
    wr(`SDD_OFF_IRQ_EN, 32'h3);
    repeat (2) @(posedge aclk);
    chk("enabled", 32'h1, 32'(irq));
    wr(`SDD_OFF_IRQ_CLR, 32'h3);
    repeat (2) @(posedge aclk);
    chk("cleared", 32'h0, 32'(irq));
    rchk("status", `SDD_OFF_IRQ_STAT, 32'h0);
    mode <= 2'h0;
    wr(`SDD_OFF_CTRL, 32'h1);
    wait_rdy(5 * PER);
    wait_rdy(2 * PER);
    chk("period cmd", 32'(PER), 32'(n));
    res(32'h800000);
    mode <= 2'h2;
    repeat (8) @(posedge aclk);
    wr(`SDD_OFF_CFG1, 32'h6);
    wait_rdy(5 * PER);
    chk("restart", 32'h1, 32'(n >= 2 * PER));
    wait_rdy(2 * PER);
    res(32'h0);
    clock_source_select_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("osc sel", 32'h1, 32'(internal_clk_sel));
    chk("pin float", 32'h1, 32'(clk_pin_oe_n));
    wr(`SDD_OFF_CFG1, 32'h26);
    repeat (3) @(posedge aclk);
    chk("pin drive", 32'h0, 32'(clk_pin_oe_n));
    clock_source_select_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("ext sel", 32'h1, 32'(clk_pin_oe_n));
    wr(`SDD_OFF_CFG3, 32'h80);
    repeat (3) @(posedge aclk);
    chk("refbuf on", 32'h1, 32'(reference_buffer_power));
    rchk("cfg3", `SDD_OFF_CFG3, 32'h80);
    wrap_up();
  end
endmodule
